// ==== hw/fsp_defines.svh ====
// Constants of the flash self-program control block
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
// ---------------------------------------------------------------
// Control/status register
// ---------------------------------------------------------------
`define FSP_CSR_OFFSET       8'h57
`define FSP_CSR_RESET        8'h00
`define FSP_BIT_IRQ_EN       7
`define FSP_BIT_SEC_BUSY     6
`define FSP_BIT_SIG_RD       5
`define FSP_BIT_REENABLE     4
`define FSP_BIT_LOCK_SET     3
`define FSP_BIT_PAGE_WRITE   2
`define FSP_BIT_PAGE_ERASE   1
`define FSP_BIT_CMD_EN       0
`define FSP_PAT_REENABLE     5'h11
`define FSP_PAT_LOCK_SET     5'h09
`define FSP_PAT_PAGE_WRITE   5'h05
`define FSP_PAT_PAGE_ERASE   5'h03
`define FSP_PAT_BUF_LOAD     5'h01
// ---------------------------------------------------------------
// Command windows, in clock cycles
// ---------------------------------------------------------------
`define FSP_STORE_WINDOW     3'h4
`define FSP_LOAD_WINDOW      3'h3
// ---------------------------------------------------------------
// Address map, word addresses
// ---------------------------------------------------------------
`define FSP_NO_READ_WHILE_WRITE_SECTION_START       17'h1f000
`define FSP_FLASH_LAST       17'h1ffff
`define FSP_BOOT_START_11    17'h1fe00
`define FSP_BOOT_START_10    17'h1fc00
`define FSP_BOOT_START_01    17'h1f800
`define FSP_BOOT_START_00    17'h1f000
`define FSP_BLOCKED_BYTE     8'hff
`define FSP_ERASED_WORD      16'hffff
// ---------------------------------------------------------------
// Controller registers on AXI4-Lite
// ---------------------------------------------------------------
`define FSP_AXI_CSR          5'h00
`define FSP_AXI_ZPTR         5'h04
`define FSP_AXI_DATA         5'h08
`define FSP_AXI_ACTION       5'h0c
`define FSP_AXI_STATUS       5'h10
`define FSP_AXI_OKAY         2'h0
`define FSP_AXI_SLVERR       2'h2
`endif

// ==== hw/fsp_pkg.sv ====
// Types of the flash self-program control block
package fsp_pkg;
   typedef enum logic [1:0] {
      FSP_OP_ERASE,
      FSP_OP_WRITE,
      FSP_OP_LOCK
   } fsp_op_t;

   typedef enum logic {
      FSP_IDLE,
      FSP_BUSY
   } fsp_state_t;
endpackage

// ==== hw/fsp_if.sv ====
// Link between the CPU end and the flash self-program control
`timescale 1ns/1ps
`default_nettype none
interface fsp_if (input wire logic aclk);
   // CPU end drives
   logic        csr_we;
   logic [7:0]  csr_wdata;
   logic [1:0]  z_ext;
   logic [15:0] z_ptr;
   logic [7:0]  r0;
   logic [7:0]  r1;
   logic        store;
   logic        load;
   logic        gie;
   // Control end drives
   logic [7:0]  csr_rdata;
   logic [7:0]  load_data;
   logic        load_valid;
   logic        irq;
   logic        halt;
   logic        section_busy;

   modport cpu (
      output csr_we, csr_wdata, z_ext, z_ptr, r0, r1, store, load, gie,
      input  csr_rdata, load_data, load_valid, irq, halt, section_busy
   );
   modport dev (
      input  csr_we, csr_wdata, z_ext, z_ptr, r0, r1, store, load, gie,
      output csr_rdata, load_data, load_valid, irq, halt, section_busy
   );
endinterface
`default_nettype wire

// ==== hw/fsp_device.sv ====
// Flash self-program control: command register, page buffer and sequencer
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "fsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsp_device #(
   parameter int PAGE_WORDS = 128
) (
   // Clock and reset
   input  wire logic            aclk,
   input  wire logic            aresetn,
   // CPU link
   fsp_if.dev                   cpu,
   // Flash array
   output logic                 flash_start,
   output fsp_pkg::fsp_op_t     flash_op,
   output logic [9:0]           flash_page,
   output logic [7:0]           flash_lock_data,
   input  wire logic            flash_done,
   output logic [16:0]          flash_rd_addr,
   input  wire logic [15:0]     flash_rd_data,
   input  wire logic [6:0]      buf_rd_addr,
   output logic [15:0]          buf_rd_data,
   // Fuses, lock bits and signature
   input  wire logic [1:0]      boot_size_fuse,
   input  wire logic [7:0]      lock_bits,
   input  wire logic [7:0]      fuse_byte,
   input  wire logic [7:0]      sig_byte,
   output logic [16:0]          boot_reset_addr
);
   import fsp_pkg::*;

   logic [15:0] page_buf [PAGE_WORDS];
   logic [5:0]  ctrl_reg;
   logic        irq_en_reg;
   logic        sec_busy_reg;
   logic [2:0]  win_reg;
   fsp_state_t  state_reg;
   logic        halt_reg;
   logic [7:0]  load_data_reg;
   logic        load_valid_reg;
   logic [16:0] boot_reg;
   logic [16:0] z_word;
   logic [9:0]  z_page;
   logic        store_hit;
   logic        load_hit;
   logic        op_store;
   logic        plain_store;
   logic        csr_take;
   logic        abort_load;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic legal_cmd(input logic [7:0] d);
      logic [4:0] p;
      p = d[4:0];
      if (d[`FSP_BIT_SIG_RD])
         legal_cmd = (p == `FSP_PAT_BUF_LOAD);
      else
         legal_cmd = (p == `FSP_PAT_REENABLE) || (p == `FSP_PAT_LOCK_SET) ||
                     (p == `FSP_PAT_PAGE_WRITE) || (p == `FSP_PAT_PAGE_ERASE) ||
                     (p == `FSP_PAT_BUF_LOAD);
   endfunction

   function automatic logic in_rww(input logic [16:0] w);
      in_rww = (w < `FSP_NO_READ_WHILE_WRITE_SECTION_START);
   endfunction

   function automatic logic [16:0] boot_start(input logic [1:0] f);
      case (f)
         2'h3:    boot_start = `FSP_BOOT_START_11;
         2'h2:    boot_start = `FSP_BOOT_START_10;
         2'h1:    boot_start = `FSP_BOOT_START_01;
         default: boot_start = `FSP_BOOT_START_00;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Address fields and command decode
   // ---------------------------------------------------------------
   assign z_word      = {cpu.z_ext, cpu.z_ptr[15:1]};
   assign z_page      = {cpu.z_ext, cpu.z_ptr[15:8]};
   assign store_hit   = cpu.store && ctrl_reg[`FSP_BIT_CMD_EN] &&
                        (win_reg != 3'h0) && (state_reg == FSP_IDLE);
   assign load_hit    = cpu.load && ctrl_reg[`FSP_BIT_CMD_EN] &&
                        (win_reg > (`FSP_STORE_WINDOW - `FSP_LOAD_WINDOW));
   assign op_store    = store_hit && !ctrl_reg[`FSP_BIT_SIG_RD] &&
                        (ctrl_reg[`FSP_BIT_PAGE_ERASE] || ctrl_reg[`FSP_BIT_PAGE_WRITE] ||
                         ctrl_reg[`FSP_BIT_LOCK_SET]);
   assign plain_store = store_hit && (ctrl_reg[5:1] == 5'h00);
   assign csr_take    = cpu.csr_we && (state_reg == FSP_IDLE) && legal_cmd(cpu.csr_wdata);
   assign abort_load  = csr_take && cpu.csr_wdata[`FSP_BIT_REENABLE];

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq_en_reg <= 1'(`FSP_CSR_RESET >> `FSP_BIT_IRQ_EN);
      else if (cpu.csr_we)
         irq_en_reg <= cpu.csr_wdata[`FSP_BIT_IRQ_EN];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         ctrl_reg <= 6'h00;
      else if (csr_take)
         ctrl_reg <= cpu.csr_wdata[5:0];
      else if (state_reg == FSP_BUSY && flash_done)
         ctrl_reg <= 6'h00;
      else if (store_hit && !op_store)
         ctrl_reg <= 6'h00;
      else if (win_reg == 3'h1 && state_reg == FSP_IDLE && !op_store)
         ctrl_reg <= 6'h00;
   end

   // Store window counts the four cycles after a command write
   always_ff @(posedge aclk) begin
      if (!aresetn)
         win_reg <= 3'h0;
      else if (csr_take && cpu.csr_wdata[`FSP_BIT_CMD_EN])
         win_reg <= `FSP_STORE_WINDOW;
      else if (store_hit)
         win_reg <= 3'h0;
      else if (win_reg != 3'h0)
         win_reg <= win_reg - 3'h1;
   end

   // ---------------------------------------------------------------
   // Section busy flag
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn)
         sec_busy_reg <= 1'b0;
      else if (op_store && !ctrl_reg[`FSP_BIT_LOCK_SET] && in_rww({z_page, 7'h00}))
         sec_busy_reg <= 1'b1;
      else if (store_hit && ctrl_reg[`FSP_BIT_REENABLE])
         sec_busy_reg <= 1'b0;
      else if (plain_store)
         sec_busy_reg <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Flash operation sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg       <= FSP_IDLE;
         flash_start     <= 1'b0;
         flash_op        <= FSP_OP_ERASE;
         flash_page      <= 10'h000;
         flash_lock_data <= 8'h00;
         halt_reg        <= 1'b0;
      end else begin
         flash_start <= 1'b0;
         case (state_reg)
            FSP_IDLE: begin
               if (op_store) begin
                  state_reg   <= FSP_BUSY;
                  flash_start <= 1'b1;
                  flash_page  <= z_page;
                  if (ctrl_reg[`FSP_BIT_LOCK_SET]) begin
                     flash_op        <= FSP_OP_LOCK;
                     flash_lock_data <= cpu.r0;
                  end else begin
                     flash_op <= ctrl_reg[`FSP_BIT_PAGE_WRITE] ? FSP_OP_WRITE
                                                                : FSP_OP_ERASE;
                     halt_reg <= !in_rww({z_page, 7'h00});
                  end
               end
            end
            FSP_BUSY: begin
               if (flash_done) begin
                  state_reg <= FSP_IDLE;
                  halt_reg  <= 1'b0;
               end
            end
            default: state_reg <= FSP_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Temporary page buffer
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || abort_load) begin
         for (int i = 0; i < PAGE_WORDS; i++)
            page_buf[i] <= `FSP_ERASED_WORD;
      end else if (plain_store) begin
         page_buf[cpu.z_ptr[7:1]] <= {cpu.r1, cpu.r0};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         buf_rd_data <= 16'h0000;
      else
         buf_rd_data <= page_buf[buf_rd_addr];
   end

   // ---------------------------------------------------------------
   // Program-memory loads
   // ---------------------------------------------------------------
   assign flash_rd_addr = z_word;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_data_reg  <= 8'h00;
         load_valid_reg <= 1'b0;
      end else begin
         load_valid_reg <= cpu.load;
         if (cpu.load) begin
            if (load_hit && ctrl_reg[`FSP_BIT_SIG_RD])
               load_data_reg <= sig_byte;
            else if (load_hit && ctrl_reg[`FSP_BIT_LOCK_SET])
               load_data_reg <= cpu.z_ptr[0] ? fuse_byte : lock_bits;
            else if (sec_busy_reg && in_rww(z_word))
               load_data_reg <= `FSP_BLOCKED_BYTE;
            else
               load_data_reg <= cpu.z_ptr[0] ? flash_rd_data[15:8]
                                             : flash_rd_data[7:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         boot_reg <= `FSP_BOOT_START_00;
      else
         boot_reg <= boot_start(boot_size_fuse);
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign boot_reset_addr  = boot_reg;
   assign cpu.csr_rdata    = {irq_en_reg, sec_busy_reg, ctrl_reg};
   assign cpu.load_data    = load_data_reg;
   assign cpu.load_valid   = load_valid_reg;
   assign cpu.irq          = irq_en_reg && cpu.gie && !ctrl_reg[`FSP_BIT_CMD_EN];
   assign cpu.halt         = halt_reg;
   assign cpu.section_busy = sec_busy_reg;
endmodule // fsp_device
`default_nettype wire

// ==== hw/fsp_cpu_end.sv ====
// CPU end: AXI4-Lite registers that drive the flash self-program link
`include "fsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_end (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Link to the control end
   fsp_if.cpu               fsp
);
   import fsp_pkg::*;

   logic        aw_have_reg;
   logic        w_have_reg;
   logic [4:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic        do_write;
   logic [17:0] z_reg;
   logic [15:0] data_reg;
   logic        gie_reg;
   logic        store_allowed;

   // ---------------------------------------------------------------
   // Write channel: address and data in either order
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_have_reg;
   assign s_axi_wready  = !w_have_reg;
   assign do_write      = aw_have_reg && w_have_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg  <= 1'b0;
         w_have_reg   <= 1'b0;
         awaddr_reg   <= 5'h00;
         wdata_reg    <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `FSP_AXI_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_have_reg) begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_reg) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
         end
         if (do_write) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg <= `FSP_AXI_ACTION) ? `FSP_AXI_OKAY
                                                             : `FSP_AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Controller registers and link strobes
   // ---------------------------------------------------------------
   // A halted core issues no CSR write, store or load; one store at a time
   assign store_allowed = !fsp.halt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         z_reg         <= 18'h00000;
         data_reg      <= 16'h0000;
         gie_reg       <= 1'b0;
         fsp.csr_we    <= 1'b0;
         fsp.csr_wdata <= `FSP_CSR_RESET;
         fsp.store     <= 1'b0;
         fsp.load      <= 1'b0;
      end else begin
         fsp.csr_we <= 1'b0;
         fsp.store  <= 1'b0;
         fsp.load   <= 1'b0;
         if (do_write && s_axi_wstrb[0]) begin
            case (awaddr_reg)
               `FSP_AXI_CSR: begin
                  if (store_allowed) begin
                     fsp.csr_we    <= 1'b1;
                     fsp.csr_wdata <= wdata_reg[7:0];
                  end
               end
               `FSP_AXI_ZPTR:   z_reg    <= wdata_reg[17:0];
               `FSP_AXI_DATA:   data_reg <= wdata_reg[15:0];
               `FSP_AXI_ACTION: begin
                  gie_reg   <= wdata_reg[2];
                  fsp.store <= wdata_reg[0] && store_allowed;
                  fsp.load  <= wdata_reg[1] && store_allowed;
               end
               default: ;
            endcase
         end
      end
   end

   // Store addressing: Z0 forced low, word field low for page write
   always_comb begin
      fsp.z_ptr = z_reg[15:0];
      if (fsp.store) begin
         fsp.z_ptr[0] = 1'b0;
         if (fsp.csr_rdata[`FSP_BIT_PAGE_WRITE])
            fsp.z_ptr[7:1] = 7'h00;
      end
   end

   assign fsp.z_ext = z_reg[17:16];
   assign fsp.r0    = data_reg[7:0];
   assign fsp.r1    = data_reg[15:8];
   assign fsp.gie   = gie_reg;

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `FSP_AXI_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `FSP_AXI_OKAY;
         case (s_axi_araddr)
            `FSP_AXI_CSR:    s_axi_rdata <= {24'h000000, fsp.csr_rdata};
            `FSP_AXI_ZPTR:   s_axi_rdata <= {14'h0000, z_reg};
            `FSP_AXI_DATA:   s_axi_rdata <= {16'h0000, data_reg};
            `FSP_AXI_ACTION: s_axi_rdata <= {29'h00000000, gie_reg, 2'h0};
            `FSP_AXI_STATUS: s_axi_rdata <= {21'h000000, fsp.section_busy, fsp.halt,
                                             fsp.irq, fsp.load_data};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `FSP_AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // fsp_cpu_end
`default_nettype wire

// ==== tb/fsp_link_props.sv ====
// Assertions on the link between the CPU end and the flash control end
`timescale 1ns/1ps
`default_nettype none
module fsp_link_props (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // CPU end
   input wire logic        csr_we,
   input wire logic [7:0]  csr_wdata,
   input wire logic [1:0]  z_ext,
   input wire logic [15:0] z_ptr,
   input wire logic        store,
   input wire logic        load,
   input wire logic        gie,
   // Control end
   input wire logic [7:0]  csr_rdata,
   input wire logic [7:0]  load_data,
   input wire logic        load_valid,
   input wire logic        irq,
   input wire logic        halt,
   input wire logic        section_busy
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_cmd_write;
      csr_we && !halt && !csr_rdata[0] &&
      csr_wdata[5:0] inside {6'h11, 6'h09, 6'h05, 6'h03, 6'h01, 6'h21};
   endsequence
   sequence s_quiet4;
      (!store && !csr_we) [*4];
   endsequence
   sequence s_page_op;
      store && !halt && csr_rdata[5:0] inside {6'h03, 6'h05};
   endsequence
   a_window_expires: assert property (s_cmd_write ##1 s_quiet4 |=> csr_rdata[5:0] == 6'h00)
      else $error("command window overran");
   a_plain_store_done: assert property (store && !halt && csr_rdata[5:0] == 6'h01
      |=> csr_rdata[5:0] == 6'h00) else $error("plain store left command bits");
   a_bad_pattern: assert property (csr_we && !halt && !csr_rdata[0] &&
      !(csr_wdata[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01})
      |=> csr_rdata[5:0] == 6'h00) else $error("bad pattern accepted");
   a_op_holds_enable: assert property (s_page_op |=> csr_rdata[0] [*2])
      else $error("enable dropped during operation");
   a_rww_busy_set: assert property ((s_page_op and ({z_ext, z_ptr[15:8]} < 10'd992))
      |-> ##[1:2] section_busy) else $error("busy flag not set");
   a_no_read_while_write_section_halt: assert property ((s_page_op and ({z_ext, z_ptr[15:8]} >= 10'd992))
      |-> ##[1:2] halt) else $error("cpu not halted");
   a_busy_blocks: assert property (load && section_busy && !csr_rdata[0] &&
      {z_ext, z_ptr[15:1]} < 17'h1f000 |=> load_valid && load_data == 8'hff)
      else $error("busy section readable");
   a_reenable_clears: assert property (store && !halt && csr_rdata[5:0] == 6'h11
      |=> !section_busy && csr_rdata[5:0] == 6'h00) else $error("re-enable failed");
   a_irq_level: assert property (irq == (csr_rdata[7] && gie && !csr_rdata[0]))
      else $error("ready request wrong");
   a_busy_visible: assert property (section_busy == csr_rdata[6])
      else $error("busy bit mismatch");
   a_load_answer: assert property (load_valid == $past(load))
      else $error("load answer misplaced");
endmodule // fsp_link_props
`default_nettype wire

// ==== tb/flash_self_program_control_tb.sv ====
// Self-checking bench of the flash self-program control block
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_tb;
   import fsp_pkg::*;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, done = 0, fst;
   logic        awr, wrd, bv, arr, rv;
   logic [1:0]  rr, br, fuse = 0;
   logic [4:0]  aa = 0, ra = 0;
   logic [31:0] wd = 0, rdat, v;
   logic [7:0]  lk = 0, fz = 0, sg = 0, ld;
   logic [6:0]  ba = 0;
   logic [9:0]  pg;
   logic [15:0] frd, bd, d;
   logic [16:0] fra, boot;
   logic [17:0] z;
   fsp_op_t     op;
   int          n_errors = 0, checked = 0, cnt = 0;
   always #2 aclk = ~aclk;
   assign frd = fra[15:0] ^ 16'h3c5a;
   // Flash array: done pulse a few cycles after each start
   always @(posedge aclk) begin
      done <= (cnt == 1);
      cnt <= fst ? 3 + $urandom % 5 : (cnt != 0 ? cnt - 1 : 0);
   end
   fsp_if link (.aclk(aclk));
   fsp_cpu_end fsp_cpu_end_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(1'b1), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
      .fsp(link));
   fsp_device fsp_device_inst (.aclk(aclk), .aresetn(aresetn), .cpu(link),
      .flash_start(fst), .flash_op(op), .flash_page(pg), .flash_lock_data(ld),
      .flash_done(done), .flash_rd_addr(fra), .flash_rd_data(frd), .buf_rd_addr(ba),
      .buf_rd_data(bd), .boot_size_fuse(fuse), .lock_bits(lk), .fuse_byte(fz),
      .sig_byte(sg), .boot_reset_addr(boot));
   fsp_link_props fsp_link_props_inst (.aclk(aclk), .aresetn(aresetn),
      .csr_we(link.csr_we), .csr_wdata(link.csr_wdata), .z_ext(link.z_ext),
      .z_ptr(link.z_ptr), .store(link.store), .load(link.load), .gie(link.gie),
      .csr_rdata(link.csr_rdata), .load_data(link.load_data),
      .load_valid(link.load_valid), .irq(link.irq), .halt(link.halt),
      .section_busy(link.section_busy));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   function automatic logic [16:0] exp_boot(input int f);
      return 17'(18'h20000 - (18'd512 << (3 - f)));
   endfunction
   task automatic fail;
      n_errors++;
      give_verdict;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] dat);
      logic ta, tw, got;
      aa <= a;
      wd <= dat;
      awv <= 1;
      wv <= 1;
      got = 0;
      for (int n = 0; !got; n++) begin
         #1;
         ta = awr;
         tw = wrd;
         got = bv;
         @(posedge aclk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         if (n > 40) fail;
      end
   endtask
   task automatic rd(input logic [4:0] a);
      logic ta, got;
      ra <= a;
      arv <= 1;
      got = 0;
      for (int n = 0; !got; n++) begin
         #1;
         ta = arr;
         got = rv;
         v = rdat;
         @(posedge aclk);
         if (ta) arv <= 0;
         if (n > 40) fail;
      end
   endtask
   task automatic cmd(input logic [7:0] c, input logic [17:0] zz, input logic [15:0] r);
      wr(5'h04, {14'h0, zz});
      wr(5'h08, {16'h0, r});
      wr(5'h00, {24'h0, c});
      wr(5'h0c, 32'h1);
   endtask
   task automatic idle;
      int n = 0;
      #1;
      while (link.csr_rdata[0] !== 1'b0 || link.halt !== 1'b0) begin
         @(posedge aclk);
         #1;
         n++;
         if (n > 200) fail;
      end
      @(posedge aclk);
   endtask
   task automatic ldb(input logic [17:0] zz, input logic [7:0] c);
      wr(5'h04, {14'h0, zz});
      if (c != 0) wr(5'h00, {24'h0, c});
      wr(5'h0c, 32'h2);
      rd(5'h10);
   endtask
   task automatic give_verdict;
      $display("checks %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      void'($urandom(62));
      lk <= $urandom;
      fz <= $urandom;
      sg <= $urandom;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(5'h00);
      chk(v, 0);
      rd(5'h14);
      chk(rr, 2'h2);
      wr(5'h10, 32'h0);
      chk(br, 2'h2);
      for (int f = 0; f < 4; f++) begin
         fuse <= f;
         repeat (3) @(posedge aclk);
         chk(boot, exp_boot(f));
      end
      z = {10'($urandom % 992), 8'h00};
      cmd(8'h03, z, 16'h0);
      idle;
      chk(op, FSP_OP_ERASE);
      chk(pg, z[17:8]);
      ldb(z | 18'h3f, 0);
      chk(v[10:0], 11'h4ff);
      cmd(8'h11, z, 16'h0);
      ldb(z | 18'h3f, 0);
      chk(v[10:0], {3'h0, z[16:9] ^ 8'h3c});
      z = {10'(992 + $urandom % 32), 8'h00};
      cmd(8'h05, z, 16'h0);
      repeat (3) @(posedge aclk);
      chk(link.halt, 1);
      idle;
      chk(op, FSP_OP_WRITE);
      chk(pg, z[17:8]);
      for (int i = 0; i < 4; i++) begin
         z = $urandom;
         d = $urandom;
         cmd(8'h01, z, d);
         ba <= z[7:1];
         repeat (3) @(posedge aclk);
         chk(bd, d);
      end
      rd(5'h04);
      chk(v, {14'h0, z});
      wr(5'h00, 32'h11);
      idle;
      chk(bd, 16'hffff);
      d = $urandom;
      cmd(8'h09, 18'h0, d);
      idle;
      chk(op, FSP_OP_LOCK);
      chk(ld, d[7:0]);
      ldb(18'h0, 8'h09);
      chk(v[7:0], lk);
      idle;
      ldb(18'h1, 8'h09);
      chk(v[7:0], fz);
      idle;
      ldb(18'h0, 8'h21);
      chk(v[7:0], sg);
      idle;
      wr(5'h00, 32'h07);
      chk(br, 2'h0);
      rd(5'h00);
      chk(v, 0);
      wr(5'h00, 32'h80);
      wr(5'h0c, 32'h4);
      rd(5'h10);
      chk(v[8], 1);
      wr(5'h00, 32'h81);
      rd(5'h10);
      chk(v[8], 0);
      idle;
      rd(5'h10);
      chk(v[8], 1);
      give_verdict;
   end
endmodule // flash_self_program_control_tb
`default_nettype wire
